// File: design/cacs_pkg.sv
package cacs_pkg;
    localparam logic [7:0] CACS_SFR_ADDR   = 8'hD8;
    localparam logic [7:0] CACS_SFR_PAGE   = 8'h00;
    localparam logic [7:0] CACS_RESET_VAL  = 8'h00;
    localparam int         CACS_OVF_BIT    = 7;
    localparam int         CACS_RUN_BIT    = 6;
    localparam int         CACS_WATCHDOG_BIT = 5;
    localparam int         CACS_NUM_MOD    = 6;
    localparam logic [2:0] CACS_BIT_IDX_W0 = 3'h0;
endpackage : cacs_pkg

// File: design/cacs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - The overflow flag is set when the shared 16-bit counter wraps from 0xFFFF to 0x0000.
// - With the overflow source enabled, a set overflow flag requests the shared interrupt.
// - Hardware never clears the overflow or module flags; only a software write does.
// - The run bit stops the counter at 0 and lets it count at 1.
// - Module flags in bits 5 to 0 are set when that module sees a match or capture.
// - With a module source enabled, its set flag requests the shared interrupt.
// - The register answers at address 0xD8 page 0x00, supports single-bit access and resets to zero.
// - While the watchdog is enabled, writing 1 to the module 5 flag forces a registered watchdog reset one clock later.
// - While the watchdog is enabled, run-bit writes do not change counter state and the bit reads software's setting.
module cacs_ctrl #(
    parameter int NUM_MOD = cacs_pkg::CACS_NUM_MOD
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               clk_en,
    // sfr bus, same clock
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_page,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_bit_wr,
    input  wire logic [2:0]         sfr_bit_idx,
    input  wire logic [7:0]         sfr_wdata,
    output logic [7:0]              sfr_rdata,
    output logic                    sfr_sel,
    // block events
    input  wire logic               counter_overflow,
    input  wire logic [NUM_MOD-1:0] module_event,
    input  wire logic               overflow_int_en,
    input  wire logic [NUM_MOD-1:0] module_int_en,
    input  wire logic               watchdog_function_en,
    // outputs
    output logic                    counter_run_en,
    output logic                    array_irq,
    output logic                    watchdog_force_reset
);
    // bit map of the control/status byte, msb first:
    //   overflow flag, run request, then one event flag per module down to module 0.
    // every bit is read/write from software, and every flag is also set by hardware.
    // a hardware set beats a software write in the same cycle, so an event is never lost;
    // the price is that software cannot clear a flag in the very cycle its event recurs.
    // clk_en low freezes every flop here, the watchdog pulse included.
    // the watchdog pulse is registered so the reset network sees a clean level.
    // the counter, the module datapaths and the mode register live outside this block:
    // they hand in one-cycle event pulses and level enables, all on ref_clk.

    // register state, one flop group per concern
    logic               run_q;
    logic               ovf_q;
    logic [NUM_MOD-1:0] flag_q;
    logic               force_q;

    // decoded access
    logic               hit;
    logic               byte_wr;
    logic               bit_wr;
    logic [7:0]         bit_sel;
    logic [7:0]         wmask;
    logic [7:0]         wval;
    logic [7:0]         cur;

    // field write enables
    logic               ovf_wr_en;
    logic               run_wr_en;
    logic [NUM_MOD-1:0] flag_wr_en;

    // per-source set, interrupt and watchdog terms
    logic               ovf_set;
    logic [NUM_MOD-1:0] flag_set;
    logic               ovf_irq;
    logic [NUM_MOD-1:0] flag_irq;
    logic               force_d;

    // the page must match as well; the same address on another page is a different register
    assign hit     = (sfr_addr == cacs_pkg::CACS_SFR_ADDR) && (sfr_page == cacs_pkg::CACS_SFR_PAGE);
    assign sfr_sel = hit;

    // a byte write takes priority over a bit write issued in the same cycle
    assign byte_wr = hit & sfr_wr;
    assign bit_wr  = hit & sfr_bit_wr & ~sfr_wr;

    // per-bit write decode: a bit write carries its value in data bit 0
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_wr
            assign bit_sel[b] = (sfr_bit_idx == 3'(b));
            assign wmask[b]   = byte_wr | (bit_wr & bit_sel[b]);
            assign wval[b]    = byte_wr ? sfr_wdata[b] : sfr_wdata[0];
        end
    endgenerate

    assign ovf_wr_en = wmask[cacs_pkg::CACS_OVF_BIT];
    assign run_wr_en = wmask[cacs_pkg::CACS_RUN_BIT];
    assign ovf_set   = counter_overflow;
    assign flag_set  = module_event;

    // read view assembled from the package's field positions
    always_comb begin
        cur                          = cacs_pkg::CACS_RESET_VAL;
        cur[cacs_pkg::CACS_OVF_BIT]  = ovf_q;
        cur[cacs_pkg::CACS_RUN_BIT]  = run_q;
        cur[NUM_MOD-1:0]             = flag_q;
    end

    // a wrap in the same cycle as a software clear must not be lost, so the set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovf_q <= cacs_pkg::CACS_RESET_VAL[cacs_pkg::CACS_OVF_BIT];
        end else if (clk_en) begin
            if (ovf_set) begin
                ovf_q <= 1'b1;
            end else if (ovf_wr_en) begin
                ovf_q <= wval[cacs_pkg::CACS_OVF_BIT];
            end
        end
    end

    // the stored run bit is software's request and is what software reads back;
    // the watchdog forces counting through counter_run_en without altering it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q <= cacs_pkg::CACS_RESET_VAL[cacs_pkg::CACS_RUN_BIT];
        end else if (clk_en && run_wr_en) begin
            run_q <= wval[cacs_pkg::CACS_RUN_BIT];
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_MOD; i++) begin : g_flag
            assign flag_wr_en[i] = wmask[i];

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    flag_q[i] <= cacs_pkg::CACS_RESET_VAL[i];
                end else if (clk_en) begin
                    if (flag_set[i]) begin
                        flag_q[i] <= 1'b1;
                    end else if (flag_wr_en[i]) begin
                        flag_q[i] <= wval[i];
                    end
                end
            end

            assign flag_irq[i] = flag_q[i] & module_int_en[i];
        end
    endgenerate

    // a write of one to the module 5 flag while the watchdog runs is a deliberate reset request
    always_comb begin
        force_d = 1'b0;
        if (watchdog_function_en && wmask[cacs_pkg::CACS_WATCHDOG_BIT]) begin
            force_d = wval[cacs_pkg::CACS_WATCHDOG_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            force_q <= 1'b0;
        end else if (clk_en) begin
            force_q <= force_d;
        end
    end

    assign watchdog_force_reset = force_q;

    // while the watchdog runs the counter cannot be stopped from here
    assign counter_run_en = run_q | watchdog_function_en;

    // level request: stays up as long as any enabled flag is set
    assign ovf_irq   = ovf_q & overflow_int_en;
    assign array_irq = ovf_irq | (|flag_irq);

    // unselected reads return zero so the bus can or together all registers
    always_comb begin
        sfr_rdata = 8'h00;
        if (hit) begin
            sfr_rdata = cur;
        end
    end

endmodule : cacs_ctrl
`default_nettype wire

// File: verif/cacs_props.sv
`timescale 1ns/1ps
`default_nettype none
module cacs_props #(parameter int NUM_MOD = 6) (input wire logic ref_clk, rst, clk_en, sfr_wr, sfr_bit_wr,
    input wire logic sfr_sel, counter_overflow, overflow_int_en, watchdog_function_en, counter_run_en, array_irq,
    input wire logic watchdog_force_reset, input wire logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata,
    input wire logic [NUM_MOD-1:0] module_event, module_int_en);
    wire logic [7:0] d = sfr_rdata;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ovf_flag: assert property (clk_en && counter_overflow ##1 sfr_sel |-> d[7]) else $error("ovf");
    a_irq_out: assert property (sfr_sel |-> array_irq == |({d[7], d[NUM_MOD-1:0]} & {overflow_int_en, module_int_en}))
        else $error("irq");
    a_flag_hold: assert property (sfr_sel && !sfr_wr && !sfr_bit_wr ##1 sfr_sel |-> ($past(d) & ~d & 8'hBF) == 8'h00)
        else $error("flag");
    a_run_out: assert property (sfr_sel |-> counter_run_en == (d[6] | watchdog_function_en)) else $error("run");
    a_event_flag: assert property (clk_en && |module_event ##1 sfr_sel |-> (~d & $past(module_event)) == 8'h00)
        else $error("event");
    a_addr_hit: assert property (sfr_sel == (sfr_addr == 8'hD8 && sfr_page == 8'h00) && (sfr_sel || d == 8'h00))
        else $error("decode");
    a_watchdog_force: assert property (clk_en && sfr_sel && sfr_wr && watchdog_function_en && sfr_wdata[5]
        |=> watchdog_force_reset) else $error("force");
    a_write_store: assert property (clk_en && sfr_sel && sfr_wr && !counter_overflow && !(|module_event)
        ##1 sfr_sel |-> d == $past(sfr_wdata)) else $error("store");
endmodule : cacs_props
bind cacs_ctrl cacs_props #(.NUM_MOD(NUM_MOD)) u_props (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_sel(sfr_sel), .counter_overflow(counter_overflow),
    .overflow_int_en(overflow_int_en), .watchdog_function_en(watchdog_function_en),
    .counter_run_en(counter_run_en), .array_irq(array_irq), .watchdog_force_reset(watchdog_force_reset),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .module_event(module_event), .module_int_en(module_int_en));
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 0, rst, clk_en, sfr_wr, sfr_bit_wr, counter_overflow, overflow_int_en, watchdog_function_en;
    logic sfr_sel, counter_run_en, array_irq, watchdog_force_reset, force_m;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, r_q;
    logic [5:0] module_event, module_int_en;
    logic [2:0] sfr_bit_idx;
    int err_total = 0, comparisons = 0;
    wire logic hit = sfr_addr == 8'hD8 && sfr_page == 8'h00;
    cacs_ctrl dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
        .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .counter_overflow(counter_overflow),
        .module_event(module_event), .overflow_int_en(overflow_int_en), .module_int_en(module_int_en),
        .watchdog_function_en(watchdog_function_en), .counter_run_en(counter_run_en), .array_irq(array_irq),
        .watchdog_force_reset(watchdog_force_reset));
    wire logic [11:0] exp_v = {hit ? r_q : 8'h00, |({r_q[7], r_q[5:0]} & {overflow_int_en, module_int_en}),
        r_q[6] | watchdog_function_en, hit, force_m};
    wire logic [11:0] got_v = {sfr_rdata, array_irq, counter_run_en, sfr_sel, watchdog_force_reset};
    // hardware set wins over a same-cycle software clear
    function automatic logic [7:0] nxt(logic [7:0] x);
        if (hit && sfr_bit_wr) x[sfr_bit_idx] = sfr_wdata[0];
        return (hit && sfr_wr ? sfr_wdata : x) | {counter_overflow, 1'b0, module_event};
    endfunction : nxt
    always @(posedge ref_clk or posedge rst) r_q <= rst ? 8'h00 : clk_en ? nxt(r_q) : r_q;
    always @(posedge ref_clk or posedge rst) force_m <= rst ? 1'b0 : !clk_en ? force_m : watchdog_function_en
        && hit && (sfr_wr ? sfr_wdata[5] : sfr_bit_wr && sfr_bit_idx == 3'h5 && sfr_wdata[0]);
    task automatic final_report;
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial forever #12.5 ref_clk = ~ref_clk;
    initial begin
        #100000 err_total++;
        final_report();
    end
    initial begin
        void'($urandom(60));
        for (int i = 0; i < 3000; i++) begin
            rst = i < 8 || i == 1500;
            {sfr_wdata, sfr_bit_idx, module_int_en, overflow_int_en, watchdog_function_en} = 19'($urandom);
            {clk_en, sfr_wr, sfr_bit_wr, counter_overflow, module_event} = {$urandom % 8 > 0, 9'($urandom & $urandom)};
            {sfr_addr, sfr_page} = $urandom % 8 ? 16'hD800 : 16'($urandom);
            if (i % 64 == 9) {clk_en, sfr_wr, sfr_addr, sfr_page, sfr_wdata, module_event} = 32'hF600003F;
            @(negedge ref_clk);
            comparisons++;
            if (got_v !== exp_v) begin
                err_total++;
                $display("MISMATCH %0t %h %h", $time, got_v, exp_v);
            end
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
